// File: rtl/ciee_pkg.sv
package ciee_pkg;
    localparam int XLEN = 32;
    // Offsets from vector_base; VEC_RESET is absolute
    localparam logic [31:0] VEC_INTERRUPT = 32'h00000600;
    localparam logic [31:0] VEC_GENERAL = 32'h00000100;
    localparam logic [31:0] VEC_RESET = 32'hA0000000;
    // Event codes
    localparam logic [31:0] CODE_NMI = 32'h000001C0;
    localparam logic [31:0] CODE_DOUBLE_FAULT = 32'h00000020;
    localparam logic [31:0] CODE_IRQ_MIN = 32'h00000400;
    localparam logic [31:0] CODE_IRQ_MAX = 32'h00003FE0;
    localparam logic [3:0] MASK_ALL = 4'hF;
    // status_word fields
    localparam int SW_PRIV = 30;
    localparam int SW_BANK = 29;
    localparam int SW_HOLD = 28;
    localparam int SW_MASK_LO = 4;
    localparam logic [31:0] SW_RESET = 32'h700000F0;
    // AXI register map (byte addresses)
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_SAVED_PC = 8'h04;
    localparam logic [7:0] A_SAVED_STATUS = 8'h08;
    localparam logic [7:0] A_SAVED_SP = 8'h0C;
    localparam logic [7:0] A_INT_CODE = 8'h10;
    localparam logic [7:0] A_EXC_CODE = 8'h14;
    localparam logic [7:0] A_VBASE = 8'h18;
    localparam logic [7:0] A_OPMODE = 8'h1C;
    localparam logic [7:0] A_PC = 8'h20;
    localparam logic [7:0] A_LINK = 8'h24;
    localparam int OPM_MU = 0;
    localparam int OPM_NMI_BL = 1;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Per-boundary report from the pipeline
    typedef struct packed {
        logic valid;         // Instruction boundary reached
        logic [31:0] pc;     // PC of the retiring instruction
        logic [31:0] next_pc;// PC of following instruction or branch target
        logic [31:0] stack;  // Current stack_register value
        logic is_branch;     // Delayed branch with slot
        logic is_rte;
        logic is_ldc_sr;
        logic [31:0] ldc_value;
        logic sleeping;
    } ciee_insn_t;

    // Exception flags: [0..3] level1-2 reexec, [4] completion lvl2,
    // [5] level3, [6] level4; transfer checks per access
    typedef struct packed {
        logic [3:0] xfer1;   // addr err, tlb miss, protect, first write
        logic [3:0] xfer2;
        logic reexec_hi;
        logic compl_l2;
        logic level3;
        logic level4;
        logic user_break;
    } ciee_exc_t;

    typedef enum logic [2:0] {
        CAUSE_NONE, CAUSE_NMI, CAUSE_IRQ, CAUSE_REEXEC, CAUSE_COMPL, CAUSE_DOUBLE
    } ciee_cause_t;
endpackage

// File: rtl/ciee_top.sv
`timescale 1ns/1ps
module ciee_top
    import ciee_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic nmi_pin,
    input wire logic [3:0] irq_level,
    input wire logic [31:0] irq_code,
    input wire ciee_insn_t insn,
    input wire ciee_exc_t branch_exc,
    input wire ciee_exc_t slot_exc,
    input wire logic slot_valid,
    input wire logic rte_slot,
    input wire logic link_write,
    input wire logic [31:0] link_value,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic redirect,
    output logic [31:0] redirect_pc,
    output logic manual_reset,
    output logic [31:0] status_word_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] status_word, saved_pc, saved_status, saved_stack_ptr;
    logic [31:0] interrupt_event_code, exception_event_code, vector_base;
    logic [31:0] cpu_operating_mode_reg, subroutine_link_reg;
    logic nmi_s1, nmi_s2, nmi_s3, nmi_pending;

    // Pin crosses domains; edge judged only on synchronised copies
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nmi_s1 <= 1'b0;
            nmi_s2 <= 1'b0;
            nmi_s3 <= 1'b0;
        end else begin
            nmi_s1 <= nmi_pin;
            nmi_s2 <= nmi_s1;
            nmi_s3 <= nmi_s2;
        end
    end
    wire nmi_edge = nmi_s2 & ~nmi_s3;

    function automatic logic any_hit(input ciee_exc_t e);
        any_hit = |e.xfer1 | |e.xfer2 | e.reexec_hi;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Status after a control load is what later checks see
    wire [31:0] base_sw = insn.is_ldc_sr ? insn.ldc_value : status_word;
    // Faults in the loading insn itself still see the old hold bit
    wire hold = status_word[SW_HOLD];
    // Interrupts are taken before the next insn, so they see the loaded value
    wire int_hold = base_sw[SW_HOLD];
    wire [3:0] cur_mask = base_sw[SW_MASK_LO +: 4];
    wire mask_upd = cpu_operating_mode_reg[OPM_MU];
    wire boundary = insn.valid;
    // Sleep lifts the hold
    wire hold_eff = int_hold & ~insn.sleeping;
    wire nmi_ok = nmi_pending & (~hold_eff | cpu_operating_mode_reg[OPM_NMI_BL]);
    wire irq_ok = ~hold_eff & (irq_level > cur_mask);
    // Ordered branch-then-slot checks; level 3 and 4 merged across both
    wire br_reexec = any_hit(branch_exc);
    wire sl_reexec = slot_valid & any_hit(slot_exc);
    wire br_compl = branch_exc.compl_l2;
    wire sl_compl = slot_valid & slot_exc.compl_l2;
    wire lvl34 = branch_exc.level3 | branch_exc.level4 | (slot_valid & (slot_exc.level3
        | slot_exc.level4));
    wire ubrk = branch_exc.user_break | (slot_valid & ~rte_slot & slot_exc.user_break);
    wire reexec = br_reexec | sl_reexec | lvl34;
    wire compl = br_compl | sl_compl;
    wire gen_exc = reexec | compl;

    ciee_cause_t cause;
    assign cause = !boundary ? CAUSE_NONE :
        (gen_exc & hold) ? CAUSE_DOUBLE :
        nmi_ok ? CAUSE_NMI :
        reexec ? CAUSE_REEXEC :
        irq_ok ? CAUSE_IRQ :
        (compl | (ubrk & ~hold_eff)) ? CAUSE_COMPL : CAUSE_NONE;

    // Re-execution and double fault resume at the faulting insn (or its branch); the rest resume after
    wire [31:0] resume_pc = (cause == CAUSE_REEXEC || cause == CAUSE_DOUBLE) ? insn.pc
        : insn.next_pc;
    wire [31:0] entry_sw = base_sw | (32'h1 << SW_PRIV) | (32'h1 << SW_BANK)
        | (32'h1 << SW_HOLD);
    wire [3:0] new_mask = (cause == CAUSE_NMI) ? MASK_ALL : irq_level;
    wire mask_write = mask_upd & (cause == CAUSE_NMI || cause == CAUSE_IRQ);
    wire [31:0] final_sw = mask_write ? {entry_sw[31:SW_MASK_LO+4], new_mask,
        entry_sw[SW_MASK_LO-1:0]} : entry_sw;
    wire taken = cause != CAUSE_NONE;
    wire irq_code_ok = irq_code >= CODE_IRQ_MIN && irq_code <= CODE_IRQ_MAX;

    ////////////////////////////////////////////////////////////////////////
    // Ready flags are flops so every bus output leaves a register
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    wire aw_hold = ~s_axi_awready;
    wire w_hold = ~s_axi_wready;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_hold & w_hold & ~s_axi_bvalid;
    wire wr_sw = wr_go && aw_addr == A_STATUS;
    wire wr_vb = wr_go && aw_addr == A_VBASE;
    wire wr_op = wr_go && aw_addr == A_OPMODE;
    wire wr_ok = wr_go && (aw_addr == A_STATUS || aw_addr == A_VBASE || aw_addr == A_OPMODE);
    wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
    wire rd_ok = s_axi_araddr <= A_LINK && s_axi_araddr[1:0] == 2'b00;
    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            A_STATUS: rd_mux = status_word;
            A_SAVED_PC: rd_mux = saved_pc;
            A_SAVED_STATUS: rd_mux = saved_status;
            A_SAVED_SP: rd_mux = saved_stack_ptr;
            A_INT_CODE: rd_mux = interrupt_event_code;
            A_EXC_CODE: rd_mux = exception_event_code;
            A_VBASE: rd_mux = vector_base;
            A_OPMODE: rd_mux = cpu_operating_mode_reg;
            A_PC: rd_mux = redirect_pc;
            A_LINK: rd_mux = subroutine_link_reg;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Address and data are latched in either order; a take and a commit never coincide
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            aw_addr <= 8'h00;
        end else if (aw_take) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b1;
            w_data <= 32'h00000000;
        end else if (w_take) begin
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
        end else if (wr_go) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OK : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // One read at a time: the address channel closes while data stands
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OK;
            s_axi_rdata <= 32'h00000000;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? RESP_OK : RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nmi_pending <= 1'b0;
        end else if (nmi_edge) begin
            nmi_pending <= 1'b1; // New edge wins over the acceptance clear
        end else if (cause == CAUSE_NMI) begin
            nmi_pending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire is_double = cause == CAUSE_DOUBLE;
    wire is_entry = taken & ~is_double;
    wire is_int = cause == CAUSE_NMI || cause == CAUSE_IRQ;
    wire rte_go = boundary & insn.is_rte & ~taken;
    wire ldc_go = boundary & insn.is_ldc_sr;
    // Priority: fault reset, entry, return, control load, then bus write
    wire [31:0] next_status_word = is_double ? SW_RESET :
        is_entry ? final_sw :
        rte_go ? saved_status :
        ldc_go ? insn.ldc_value :
        wr_sw ? w_data : status_word;
    wire [31:0] next_redirect_pc = is_double ? VEC_RESET :
        is_int ? vector_base + VEC_INTERRUPT :
        taken ? vector_base + VEC_GENERAL :
        rte_go ? saved_pc : redirect_pc;
    // Out-of-range source codes fall back to the lowest legal code
    wire [31:0] next_int_code = (cause == CAUSE_NMI) ? CODE_NMI :
        ~irq_code_ok ? CODE_IRQ_MIN : irq_code;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_word <= SW_RESET;
        end else begin
            status_word <= next_status_word;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            saved_pc <= 32'h00000000;
        end else if (taken) begin
            saved_pc <= resume_pc;
        end
    end

    // Double fault leaves saved status and stack as they were
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            saved_status <= 32'h00000000;
            saved_stack_ptr <= 32'h00000000;
        end else if (is_entry) begin
            saved_status <= base_sw;
            saved_stack_ptr <= insn.stack;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_event_code <= 32'h00000000;
        end else if (is_int) begin
            interrupt_event_code <= next_int_code;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            exception_event_code <= 32'h00000000;
        end else if (is_double) begin
            exception_event_code <= CODE_DOUBLE_FAULT;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vector_base <= 32'h00000000;
        end else if (wr_vb) begin
            vector_base <= w_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_operating_mode_reg <= 32'h00000000;
        end else if (wr_op) begin
            cpu_operating_mode_reg <= w_data;
        end
    end

    // Slot fault does not cancel the link write; value is then undefined
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            subroutine_link_reg <= 32'h00000000;
        end else if (link_write) begin
            subroutine_link_reg <= link_value;
        end
    end

    // Redirect and manual reset are one-cycle pulses
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            redirect <= 1'b0;
            redirect_pc <= 32'h00000000;
            manual_reset <= 1'b0;
        end else begin
            redirect <= taken | rte_go;
            redirect_pc <= next_redirect_pc;
            manual_reset <= is_double;
        end
    end
    assign status_word_out = status_word;
endmodule // ciee_top

// File: verif/ciee_top_monitor.sv
`timescale 1ns/1ps
module ciee_top_monitor
    import ciee_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic nmi_pin,
    input wire logic [3:0] irq_level,
    input wire ciee_insn_t insn,
    input wire ciee_exc_t branch_exc,
    input wire ciee_exc_t slot_exc,
    input wire logic redirect,
    input wire logic manual_reset,
    input wire logic [31:0] status_word_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    // An edge seen on the pin stays owed until an entry; the mask cannot see it
    logic owed;
    wire hold = status_word_out[SW_HOLD];
    wire [3:0] mask = status_word_out[7:4];
    wire quiet = !owed && !nmi_pin && branch_exc == '0 && slot_exc == '0 && !insn.is_rte
        && !insn.is_ldc_sr;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) owed <= 1'b0;
        else if (nmi_pin) owed <= 1'b1;
        else if (redirect && !$past(insn.is_rte)) owed <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_entry;
        redirect && status_word_out[30:28] == 3'b111;
    endsequence
    AST_IRQ_TAKE: assert property (insn.valid && !hold && irq_level > mask && quiet
        |=> s_entry) else $error("request above mask not taken");
    AST_MASK_BLOCK: assert property (insn.valid && !hold && irq_level <= mask && quiet
        |=> !redirect) else $error("request at or below mask taken");
    AST_BOUNDARY: assert property (redirect |-> $past(insn.valid))
        else $error("redirect without instruction boundary");
    AST_HOLD_BLOCK: assert property (insn.valid && hold && !insn.sleeping && quiet
        |=> !redirect) else $error("request taken while hold set");
    AST_SLEEP: assert property (insn.valid && insn.sleeping && irq_level > mask && quiet
        |=> s_entry) else $error("request not taken in sleep");
    AST_DOUBLE: assert property (insn.valid && hold && !insn.sleeping && branch_exc.reexec_hi
        |=> manual_reset) else $error("fault under hold without manual reset");
    AST_UBRK: assert property (insn.valid && hold && branch_exc == 13'h0001 && slot_exc == '0
        |=> !manual_reset) else $error("user break under hold caused manual reset");
    AST_ENTRY: assert property (redirect && !manual_reset
        && $past(insn.valid) && !$past(insn.is_rte) && !$past(insn.is_ldc_sr)
        |-> status_word_out[30:28] == 3'b111)
        else $error("entry without hold, privilege and bank bits");
endmodule // ciee_top_monitor

// File: verif/ciee_intc_model.sv
`timescale 1ns/1ps
module ciee_intc_model
    import ciee_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] req_lvl,
    input wire logic [31:0] req_code,
    input wire logic nmi_go,
    output logic nmi_pin,
    output logic [3:0] irq_level,
    output logic [31:0] irq_code
);
    logic [2:0] pulse_cnt;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt <= 3'h0;
            nmi_pin <= 1'b0;
            irq_level <= 4'h0;
            irq_code <= 32'h0;
        end else begin
            // Pin held four cycles so the two-stage synchroniser cannot miss it
            pulse_cnt <= nmi_go ? 3'h4 : pulse_cnt - {2'h0, pulse_cnt != 3'h0};
            nmi_pin <= pulse_cnt != 3'h0;
            irq_level <= req_lvl;
            // No request: code means nothing, so it keeps moving
            irq_code <= (req_lvl == 4'h0) ? ~irq_code : req_code;
        end
    end
endmodule // ciee_intc_model

// File: verif/ciee_top_tb.sv
`timescale 1ns/1ps
module ciee_top_tb import ciee_pkg::*;;
    logic clock, rst_n, nmi_pin, nmi_go, redirect, manual_reset;
    logic [3:0] irq_level, req_lvl, s_axi_wstrb;
    logic [31:0] irq_code, req_code, redirect_pc, status_word_out, s_axi_wdata, s_axi_rdata;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    ciee_insn_t insn;
    ciee_exc_t branch_exc;
    int miscompares, num_checks;
    ciee_top uut (.*, .slot_exc('0), .slot_valid(1'b0), .rte_slot(1'b0), .link_write(1'b0),
        .link_value(32'h0));
    ciee_intc_model pm (.*);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        if (miscompares == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clock);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            if (tb) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) break;
        end
        s_axi_bready <= 1'b0;
        @(posedge clock);
        if (n == 40) begin
            miscompares++;
            test_done;
        end
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        logic ta, tr;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clock);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            if (tr) chk("rdata", e, s_axi_rdata);
            if (tr) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
            @(posedge clock);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) break;
        end
        s_axi_rready <= 1'b0;
        @(posedge clock);
        if (n == 40) begin
            miscompares++;
            test_done;
        end
    endtask
    // One boundary; an unknown er leaves redirect unjudged
    task automatic bnd(input logic [31:0] pc, input logic return_from_exception, input logic slp,
        input logic [12:0] x, input logic er, input logic [31:0] ep, input logic em);
        insn <= '{1'b1, pc, pc + 32'h2, pc + 32'h100, 1'b0, return_from_exception, 1'b0, 32'h0, slp};
        branch_exc <= x;
        @(posedge clock);
        insn.valid <= 1'b0;
        branch_exc <= '0;
        @(negedge clock);
        if (er !== 1'bx) chk("redirect", {31'h0, er}, {31'h0, redirect});
        if (er === 1'b1) chk("redirect_pc", ep, redirect_pc);
        chk("manual_reset", {31'h0, em}, {31'h0, manual_reset});
        @(posedge clock);
    endtask
    task automatic req(input logic [3:0] l, input logic [31:0] c);
        req_lvl <= l;
        req_code <= c;
        repeat (2) @(posedge clock);
    endtask
    task automatic nmi;
        nmi_go <= 1'b1;
        @(posedge clock);
        nmi_go <= 1'b0;
        repeat (6) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, nmi_go, req_lvl, req_code, insn, branch_exc} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        miscompares = 0;
        num_checks = 0;
        repeat (6) @(posedge clock);
        chk("status", SW_RESET, status_word_out);
        rst_n <= 1'b1;
        axw(A_VBASE, 32'h80000000, RESP_OK);
        axw(A_OPMODE, 32'h00000001, RESP_OK);
        axw(A_STATUS, 32'h40000030, RESP_OK);
        req(4'h3, 32'h00000420);
        bnd(32'h1000, 1'b0, 1'b0, 13'h0, 1'b0, 32'h0, 1'b0);
        req(4'h4, 32'h00000420);
        bnd(32'h1000, 1'b0, 1'b0, 13'h0, 1'b1, 32'h80000600, 1'b0);
        chk("mask", 32'h4, {28'h0, status_word_out[7:4]});
        axr(A_INT_CODE, 32'h00000420, RESP_OK);
        axr(A_SAVED_PC, 32'h00001002, RESP_OK);
        axr(A_SAVED_STATUS, 32'h40000030, RESP_OK);
        axr(A_SAVED_SP, 32'h00001100, RESP_OK);
        req(4'h9, 32'h00000520);
        bnd(32'h2000, 1'b0, 1'b0, 13'h0, 1'b0, 32'h0, 1'b0);
        bnd(32'h2000, 1'b0, 1'b1, 13'h0, 1'b1, 32'h80000600, 1'b0);
        axw(A_STATUS, 32'h40000000, RESP_OK);
        bnd(32'h2004, 1'b0, 1'b0, 13'h0, 1'b1, 32'h80000600, 1'b0);
        axw(A_STATUS, 32'h40000000, RESP_OK);
        req(4'h5, 32'h00000500);
        nmi();
        bnd(32'h3000, 1'b0, 1'b0, 13'h0, 1'b1, 32'h80000600, 1'b0);
        chk("mask", 32'hF, {28'h0, status_word_out[7:4]});
        axr(A_INT_CODE, CODE_NMI, RESP_OK);
        req(4'h0, 32'h0);
        nmi();
        // Held under hold: the select bit was left clear
        bnd(32'h3100, 1'b0, 1'b0, 13'h0, 1'b0, 32'h0, 1'b0);
        bnd(32'h3200, 1'b1, 1'b0, 13'h0, 1'b1, 32'h00003002, 1'b0);
        chk("status", 32'h40000000, status_word_out);
        bnd(32'h3300, 1'b0, 1'b0, 13'h0, 1'b1, 32'h80000600, 1'b0);
        bnd(32'h3400, 1'b0, 1'b0, 13'h0001, 1'b0, 32'h0, 1'b0);
        bnd(32'h3500, 1'b0, 1'b0, 13'h0010, 1'b1, VEC_RESET, 1'b1);
        axr(A_EXC_CODE, CODE_DOUBLE_FAULT, RESP_OK);
        axr(A_SAVED_PC, 32'h00003500, RESP_OK);
        axr(8'h28, 32'h0, RESP_DECERR);
        axw(A_SAVED_PC, 32'h00000001, RESP_DECERR);
        axw(A_OPMODE, 32'h00000003, RESP_OK);
        nmi();
        bnd(32'h3600, 1'b0, 1'b0, 13'h0, 1'b1, 32'h80000600, 1'b0);
        axr(A_SAVED_PC, 32'h00003602, RESP_OK);
        test_done;
    end
endmodule // ciee_top_tb
bind ciee_top ciee_top_monitor mon (.clock, .rst_n, .nmi_pin, .irq_level, .insn, .branch_exc,
    .slot_exc, .redirect, .manual_reset, .status_word_out);
